// [logic/vita_pkg.sv]
// Notes on behaviour
// (RQ1) The timer assist runs only while enable bits 0 and 7 of the assist control word are both one.
// (RQ2) The timer assist works on its own and calls on no other assist unit.
// (RQ3) The guest timer word lives at location 80 of the guest's page zero.
// (RQ4) Guests in basic control mode and in extended control mode are both served.
// (RQ5) Each real timer decrement in problem state also subtracts one at bit position 23 of the guest word.
// (RQ6) While guest page zero is absent the word is held in the guest control block copy until the page loads.
// (RQ7) In the wait state counting is optional and here follows a software enable.
// (RQ8) A decrement that takes the word from non-negative to negative raises a pending guest timer interruption.
// (RQ9) Guest delivery needs the guest enabled for timer interruptions, page zero resident and a valid external new status word.
// (RQ10) The current and external new guest status words are compared and an illegal state change withholds delivery.
// (RQ11) An undeliverable interruption goes to the real processor when it is enabled for interval timer interruptions.
// (RQ12) The real processor sees a guest timer interruption code distinct from the real timer code.
// (RQ13) In supervisor state without waiting the guest word is left unchanged.
package vita_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_TIMER  = 8'h04;
	localparam logic [7:0]  OFF_STATUS = 8'h08;
	localparam logic [7:0]  OFF_MASK   = 8'h0C;
	localparam logic [7:0]  OFF_STATE  = 8'h10;

	// ****************************************************************
	// Control fields and reset values
	// ****************************************************************
	localparam int          CTRL_ASSIST_BIT = 0;
	localparam int          CTRL_TIMER_BIT  = 7;
	localparam int          CTRL_WAIT_BIT   = 8;
	localparam logic [8:0]  CTRL_RESET      = 9'h000;
	localparam logic [31:0] TIMER_RESET     = 32'h0000_0000;
	localparam logic [3:0]  MASK_RESET      = 4'h0;

	// ****************************************************************
	// Status bits
	// ****************************************************************
	localparam int          ST_CROSSED  = 0;
	localparam int          ST_GUEST    = 1;
	localparam int          ST_REAL     = 2;
	localparam int          ST_WITHHELD = 3;

	// ****************************************************************
	// Timer word, storage and codes
	// ****************************************************************
	localparam logic [23:0] GUEST_TIMER_LOC = 24'h00_0050;
	localparam logic [31:0] DEC_STEP        = 32'h0000_0100;
	localparam logic [15:0] CODE_REAL_TIMER = 16'h0080;
	localparam logic [15:0] CODE_GUEST_TIMER = 16'h0081;

	// ****************************************************************
	// Status word fields
	// ****************************************************************
	localparam int          PSW_EXT_MASK = 7;
	localparam int          PSW_EC_MODE  = 12;

	typedef enum logic [2:0] {
		VITA_IDLE = 3'b001,
		VITA_PEND = 3'b010,
		VITA_REAL = 3'b100
	} vita_state_type;

endpackage

// [logic/vita_timer_assist.sv]
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module vita_timer_assist (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdData,
	output logic             irq,
	input  wire logic        realTick,
	input  wire logic        problemState,
	input  wire logic        waitState,
	input  wire logic        realTimerEnabled,
	input  wire logic        pageResident,
	input  wire logic [23:0] guestPageBase,
	input  wire logic [63:0] guestCurPsw,
	input  wire logic [63:0] guestNewPsw,
	input  wire logic        guestTimerSubmask,
	output logic             memWrite,
	output logic      [23:0] memAddr,
	output logic      [31:0] memData,
	output logic             guestIntReq,
	output logic             realIntReq,
	output logic      [15:0] realIntCode,
	input  wire logic        realIntAck
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [8:0]              ctrl_q,     ctrl_d;
	logic [31:0]             timer_q,    timer_d;
	logic [3:0]              status_q,   status_d;
	logic [3:0]              mask_q,     mask_d;
	logic                    dirty_q,    dirty_d;
	logic                    resPrev_q;
	logic [31:0]             rdData_q,   rdData_d;
	logic                    memWr_q,    memWr_d;
	logic [23:0]             memAddr_q,  memAddr_d;
	logic [31:0]             memData_q,  memData_d;
	logic                    guestReq_q, guestReq_d;
	logic                    realReq_q,  realReq_d;
	vita_pkg::vita_state_type state_q,   state_d;

	logic                    assistOn;
	logic                    countNow;
	logic [31:0]             timerDec;
	logic                    crossed;
	logic                    guestEnabled;
	logic                    formatOk;
	logic                    illegalChange;
	logic                    guestOk;
	logic [3:0]              setBits;
	logic                    wrTimer;
	logic                    pageLoaded;

	// ****************************************************************
	// Timer maintenance
	// ****************************************************************
	// Only the two enables together switch the assist on
	assign assistOn = ctrl_q[vita_pkg::CTRL_ASSIST_BIT] &
		ctrl_q[vita_pkg::CTRL_TIMER_BIT]; // RQ1

	// Problem state counts, wait counts when allowed, supervisor holds
	assign countNow = assistOn & realTick & (problemState |
		(waitState & ctrl_q[vita_pkg::CTRL_WAIT_BIT])); // RQ5 RQ7 RQ13

	// One unit at bit 23 of the word, counted from the left
	assign timerDec = timer_q - vita_pkg::DEC_STEP; // RQ5

	assign crossed = countNow & ~timer_q[31] & timerDec[31]; // RQ8

	assign wrTimer = regWrite & (regAddr == vita_pkg::OFF_TIMER);

	assign pageLoaded = pageResident & ~resPrev_q;

	// ****************************************************************
	// Guest delivery checks
	// ****************************************************************
	// Basic mode uses the external mask, extended mode adds the submask
	always_comb begin
		if (guestCurPsw[63 - vita_pkg::PSW_EC_MODE]) begin // RQ4
			guestEnabled = guestCurPsw[63 - vita_pkg::PSW_EXT_MASK] &
				guestTimerSubmask;
		end else begin
			guestEnabled = guestCurPsw[63 - vita_pkg::PSW_EXT_MASK];
		end
	end

	// Extended format needs bits 0 and 2 to 4 zero
	assign formatOk = ~guestNewPsw[63 - vita_pkg::PSW_EC_MODE] |
		~(guestNewPsw[63] | (|guestNewPsw[61:59])); // RQ9

	// A mode switch on interruption is an illegal change
	assign illegalChange = guestCurPsw[63 - vita_pkg::PSW_EC_MODE] ^
		guestNewPsw[63 - vita_pkg::PSW_EC_MODE]; // RQ10

	assign guestOk = guestEnabled & pageResident & formatOk &
		~illegalChange; // RQ9 RQ10

	// ****************************************************************
	// Timer word and storage mirror
	// ****************************************************************
	// The internal word is the control block copy; storage gets it
	// only while page zero is resident
	always_comb begin
		timer_d   = timer_q;
		dirty_d   = dirty_q;
		memWr_d   = 1'b0;
		memAddr_d = memAddr_q;
		memData_d = memData_q;
		if (pageResident && dirty_q) begin // RQ6
			memWr_d   = 1'b1;
			memAddr_d = guestPageBase + vita_pkg::GUEST_TIMER_LOC; // RQ3
			memData_d = timer_q;
			dirty_d   = 1'b0;
		end
		if (wrTimer) begin
			timer_d = regWrData;
			dirty_d = 1'b1;
		end else if (countNow) begin
			timer_d = timerDec; // RQ5
			dirty_d = 1'b1;
		end
		if (pageLoaded) begin
			dirty_d = 1'b1; // RQ6
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			timer_q   <= vita_pkg::TIMER_RESET;
			dirty_q   <= 1'b0;
			resPrev_q <= 1'b1;
			memWr_q   <= 1'b0;
			memAddr_q <= 24'h00_0000;
			memData_q <= 32'h0000_0000;
		end else begin
			timer_q   <= timer_d;
			dirty_q   <= dirty_d;
			resPrev_q <= pageResident;
			memWr_q   <= memWr_d;
			memAddr_q <= memAddr_d;
			memData_q <= memData_d;
		end
	end

	// ****************************************************************
	// Interruption sequencer
	// ****************************************************************
	// Works alone; no other assist unit is consulted
	always_comb begin
		state_d    = state_q; // RQ2
		guestReq_d = 1'b0;
		realReq_d  = realReq_q;
		setBits    = 4'h0;
		if (crossed) begin
			setBits[vita_pkg::ST_CROSSED] = 1'b1;
		end
		case (state_q)
			vita_pkg::VITA_IDLE: begin
				if (crossed) begin
					state_d = vita_pkg::VITA_PEND; // RQ8
				end
			end
			vita_pkg::VITA_PEND: begin
				if (guestOk) begin
					guestReq_d = 1'b1; // RQ9
					setBits[vita_pkg::ST_GUEST] = 1'b1;
					state_d = vita_pkg::VITA_IDLE;
				end else if (realTimerEnabled) begin
					realReq_d = 1'b1; // RQ11
					setBits[vita_pkg::ST_REAL] = 1'b1;
					setBits[vita_pkg::ST_WITHHELD] = 1'b1;
					state_d = vita_pkg::VITA_REAL;
				end else begin
					setBits[vita_pkg::ST_WITHHELD] = 1'b1;
				end
			end
			vita_pkg::VITA_REAL: begin
				if (realIntAck) begin
					realReq_d = 1'b0;
					state_d   = vita_pkg::VITA_IDLE;
				end
			end
			default: begin
				state_d   = vita_pkg::VITA_IDLE;
				realReq_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q    <= vita_pkg::VITA_IDLE;
			guestReq_q <= 1'b0;
			realReq_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			guestReq_q <= guestReq_d;
			realReq_q  <= realReq_d;
		end
	end

	// ****************************************************************
	// Register bus
	// ****************************************************************
	always_comb begin
		ctrl_d   = ctrl_q;
		mask_d   = mask_q;
		status_d = status_q;
		rdData_d = 32'h0000_0000;
		if (regWrite) begin
			case (regAddr)
				vita_pkg::OFF_CTRL:   ctrl_d = regWrData[8:0];
				vita_pkg::OFF_MASK:   mask_d = regWrData[3:0];
				vita_pkg::OFF_STATUS: status_d = status_q & ~regWrData[3:0];
				default:              ctrl_d = ctrl_q;
			endcase
		end
		// Hardware set wins over a clear in the same cycle
		status_d = status_d | setBits;
		if (regRead) begin
			case (regAddr)
				vita_pkg::OFF_CTRL:   rdData_d = {23'h00_0000, ctrl_q};
				vita_pkg::OFF_TIMER:  rdData_d = timer_q;
				vita_pkg::OFF_STATUS: rdData_d = {28'h000_0000, status_q};
				vita_pkg::OFF_MASK:   rdData_d = {28'h000_0000, mask_q};
				vita_pkg::OFF_STATE:  rdData_d = {27'h000_0000, dirty_q,
					pageResident, state_q};
				default:              rdData_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q   <= vita_pkg::CTRL_RESET;
			mask_q   <= vita_pkg::MASK_RESET;
			status_q <= 4'h0;
			rdData_q <= 32'h0000_0000;
		end else begin
			ctrl_q   <= ctrl_d;
			mask_q   <= mask_d;
			status_q <= status_d;
			rdData_q <= rdData_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign regRdData   = rdData_q;
	assign irq         = |(status_q & mask_q);
	assign memWrite    = memWr_q;
	assign memAddr     = memAddr_q;
	assign memData     = memData_q;
	assign guestIntReq = guestReq_q;
	assign realIntReq  = realReq_q;
	// Guest timer code differs from the real timer code
	assign realIntCode = realReq_q ? vita_pkg::CODE_GUEST_TIMER :
		vita_pkg::CODE_REAL_TIMER; // RQ12

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_no_count_disabled;
		@(posedge clock) disable iff (reset)
		!assistOn |=> timer_q == $past(timer_q) ||
			$past(wrTimer);
	endproperty
	a_no_count_disabled: assert property (p_no_count_disabled) // RQ1
		else $error("timer moved while assist disabled");

	property p_decrement;
		@(posedge clock) disable iff (reset)
		countNow && !wrTimer |=>
			timer_q == $past(timer_q) - vita_pkg::DEC_STEP;
	endproperty
	a_decrement: assert property (p_decrement) // RQ5
		else $error("timer did not step by one bit 23 unit");

	property p_supervisor_hold;
		@(posedge clock) disable iff (reset)
		!problemState && !waitState && !wrTimer |=>
			timer_q == $past(timer_q);
	endproperty
	a_supervisor_hold: assert property (p_supervisor_hold) // RQ13
		else $error("timer changed in supervisor state");

	property p_store_loc;
		@(posedge clock) disable iff (reset)
		memWrite |-> memAddr == $past(guestPageBase) +
			vita_pkg::GUEST_TIMER_LOC;
	endproperty
	a_store_loc: assert property (p_store_loc) // RQ3
		else $error("timer word stored at wrong address");

	property p_absent_no_store;
		@(posedge clock) disable iff (reset)
		!pageResident |=> !memWrite;
	endproperty
	a_absent_no_store: assert property (p_absent_no_store) // RQ6
		else $error("storage written while page absent");

	property p_cross_pending;
		@(posedge clock) disable iff (reset)
		crossed && state_q == vita_pkg::VITA_IDLE |=>
			state_q == vita_pkg::VITA_PEND;
	endproperty
	a_cross_pending: assert property (p_cross_pending) // RQ8
		else $error("crossing did not raise pending");

	property p_guest_needs_ok;
		@(posedge clock) disable iff (reset)
		guestIntReq |-> $past(guestOk) &&
			$past(state_q) == vita_pkg::VITA_PEND;
	endproperty
	a_guest_needs_ok: assert property (p_guest_needs_ok) // RQ9
		else $error("guest delivery without its conditions");

	property p_illegal_withheld;
		@(posedge clock) disable iff (reset)
		illegalChange |=> !guestIntReq;
	endproperty
	a_illegal_withheld: assert property (p_illegal_withheld) // RQ10
		else $error("delivery despite illegal state change");

	property p_real_fallback;
		@(posedge clock) disable iff (reset)
		state_q == vita_pkg::VITA_PEND && !guestOk && realTimerEnabled
			|=> realIntReq ##0 realIntCode == vita_pkg::CODE_GUEST_TIMER;
	endproperty
	a_real_fallback: assert property (p_real_fallback) // RQ11 RQ12
		else $error("fallback to real processor missing");

endmodule // vita_timer_assist

// [verif/vita_host_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// Host side: counts timer stores and acknowledges real interruptions
// ****************************************************************
module vita_host_model (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       memWrite,
	input  wire logic       realIntReq,
	input  wire logic [3:0] ackDelay,
	output logic            realIntAck,
	output int              storeCount
);
	logic [3:0] waitCnt;

	always @(posedge clock) begin
		if (reset)
			storeCount <= 0;
		else if (memWrite)
			storeCount <= storeCount + 1;
	end

	// Ack ackDelay+1 cycles after the request rises, so prompt and slow hosts are both seen
	always @(posedge clock) begin
		if (reset || !realIntReq || realIntAck) begin
			realIntAck <= 1'h0;
			waitCnt    <= 4'h0;
		end else if (waitCnt == ackDelay) begin
			realIntAck <= 1'h1;
		end else begin
			waitCnt    <= waitCnt + 4'h1;
		end
	end
endmodule // vita_host_model

// [verif/vita_timer_assist_tb.sv]
`timescale 1ns/100ps
module vita_timer_assist_tb;
	typedef struct {logic [8:0] ctrl; logic prob, wt; logic [31:0] exp;} vita_row_type;
	typedef struct {logic [63:0] cur, nw; logic sub, res, toGuest;} vita_dlv_type;
	logic clock = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, irq;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData, memData, rd;
	logic realTick = 1'h0, problemState = 1'h0, waitState = 1'h0;
	logic realTimerEnabled = 1'h1, pageResident = 1'h1, guestTimerSubmask = 1'h0;
	logic [23:0] guestPageBase = 24'h01_2000, memAddr;
	logic [63:0] guestCurPsw = 64'h0, guestNewPsw = 64'h0;
	logic memWrite, guestIntReq, realIntReq, realIntAck;
	logic [15:0] realIntCode;
	logic [3:0]  ackDelay = 4'h1;
	int n_errors = 0, checks_done = 0, storeCount, n;
	vita_row_type rows[6] = '{'{9'h081, 1'h1, 1'h0, 32'h0F00},
		'{9'h001, 1'h1, 1'h0, 32'h1000}, '{9'h080, 1'h1, 1'h0, 32'h1000},
		'{9'h081, 1'h0, 1'h0, 32'h1000}, '{9'h081, 1'h0, 1'h1, 32'h1000},
		'{9'h181, 1'h0, 1'h1, 32'h0F00}};
	vita_dlv_type dlv[7] = '{
		'{64'h0100_0000_0000_0000, 64'h0, 1'h0, 1'h1, 1'h1},
		'{64'h0108_0000_0000_0000, 64'h0008_0000_0000_0000, 1'h1, 1'h1, 1'h1},
		'{64'h0108_0000_0000_0000, 64'h0008_0000_0000_0000, 1'h0, 1'h1, 1'h0},
		'{64'h0100_0000_0000_0000, 64'h0008_0000_0000_0000, 1'h0, 1'h1, 1'h0},
		'{64'h0108_0000_0000_0000, 64'h8008_0000_0000_0000, 1'h1, 1'h1, 1'h0},
		'{64'h0, 64'h0, 1'h0, 1'h1, 1'h0},
		'{64'h0100_0000_0000_0000, 64'h0, 1'h0, 1'h0, 1'h0}};

	always #20 clock = ~clock;

	vita_timer_assist dut_u (.clock(clock), .reset(reset), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .irq(irq), .realTick(realTick),
		.problemState(problemState), .waitState(waitState),
		.realTimerEnabled(realTimerEnabled), .pageResident(pageResident),
		.guestPageBase(guestPageBase), .guestCurPsw(guestCurPsw),
		.guestNewPsw(guestNewPsw), .guestTimerSubmask(guestTimerSubmask),
		.memWrite(memWrite), .memAddr(memAddr), .memData(memData),
		.guestIntReq(guestIntReq), .realIntReq(realIntReq),
		.realIntCode(realIntCode), .realIntAck(realIntAck));

	vita_host_model host_u (.clock(clock), .reset(reset), .memWrite(memWrite),
		.realIntReq(realIntReq), .ackDelay(ackDelay),
		.realIntAck(realIntAck), .storeCount(storeCount));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic finish_test;
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regWrite  <= 1'h1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite  <= 1'h0;
	endtask

	task automatic regRd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'h0;
		#1 d = regRdData;
	endtask

	task automatic tick(input int len);
		@(posedge clock);
		realTick <= 1'h1;
		repeat (len) @(posedge clock);
		realTick <= 1'h0;
	endtask

	// Kinds: 0 store, 2 real request, 3 real request gone, 4 any delivery
	task automatic waitEvt(input int kind);
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			#1;
			if ((kind == 0 && memWrite === 1'h1) ||
			    (kind == 2 && realIntReq === 1'h1) ||
			    (kind == 3 && realIntReq === 1'h0) ||
			    (kind == 4 && (guestIntReq === 1'h1 || realIntReq === 1'h1)))
				return;
		end
		$display("mismatch at %0t: wait expired", $time);
		n_errors++;
		finish_test();
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (4) @(posedge clock);
		reset <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			regRd(8'(i * 4), rd);
			chk(rd, (i == 4) ? 32'h9 : 32'h0);
		end
		chk({16'h0, realIntCode}, 32'h0080);
		foreach (rows[i]) begin
			regWr(vita_pkg::OFF_CTRL, {23'h0, rows[i].ctrl});
			regWr(vita_pkg::OFF_TIMER, 32'h0000_1000);
			problemState <= rows[i].prob;
			waitState    <= rows[i].wt;
			tick(1);
			regRd(vita_pkg::OFF_TIMER, rd);
			chk(rd, rows[i].exp);
		end
		regWr(vita_pkg::OFF_CTRL, 32'h0000_0081);
		problemState <= 1'h1;
		waitState    <= 1'h0;
		regWr(vita_pkg::OFF_TIMER, 32'h0000_1000);
		repeat (4) @(posedge clock);
		tick(2);
		#1 chk({31'h0, memWrite}, 32'h1);
		chk({8'h0, memAddr}, {8'h0, guestPageBase + 24'h00_0050});
		chk(memData, 32'h0000_0F00);
		waitEvt(0);
		chk(memData, 32'h0000_0E00);
		repeat (4) @(posedge clock);
		pageResident <= 1'h0;
		n = storeCount;
		tick(1);
		repeat (4) @(posedge clock);
		chk(32'(storeCount), 32'(n));
		regRd(vita_pkg::OFF_TIMER, rd);
		chk(rd, 32'h0000_0D00);
		pageResident <= 1'h1;
		waitEvt(0);
		chk(memData, 32'h0000_0D00);
		foreach (dlv[i]) begin
			guestCurPsw       <= dlv[i].cur;
			guestNewPsw       <= dlv[i].nw;
			guestTimerSubmask <= dlv[i].sub;
			pageResident      <= dlv[i].res;
			ackDelay          <= 4'(i);
			regWr(vita_pkg::OFF_STATUS, 32'h0000_000F);
			regWr(vita_pkg::OFF_TIMER, 32'h0000_0080);
			tick(1);
			waitEvt(4);
			chk({31'h0, guestIntReq}, {31'h0, dlv[i].toGuest});
			if (!dlv[i].toGuest) begin
				chk({16'h0, realIntCode}, 32'h0081);
				waitEvt(3);
			end
			regRd(vita_pkg::OFF_STATUS, rd);
			chk(rd, dlv[i].toGuest ? 32'h3 : 32'hD);
		end
		realTimerEnabled <= 1'h0;
		regWr(vita_pkg::OFF_STATUS, 32'h0000_000F);
		regWr(vita_pkg::OFF_TIMER, 32'h0000_0080);
		tick(1);
		repeat (6) @(posedge clock);
		chk({31'h0, realIntReq}, 32'h0);
		regRd(vita_pkg::OFF_STATE, rd);
		chk(rd & 32'h7, 32'h2);
		realTimerEnabled <= 1'h1;
		waitEvt(2);
		chk({16'h0, realIntCode}, 32'h0081);
		waitEvt(3);
		chk({31'h0, irq}, 32'h0);
		regWr(vita_pkg::OFF_MASK, 32'h0000_0004);
		#1 chk({31'h0, irq}, 32'h1);
		regWr(vita_pkg::OFF_STATUS, 32'h0000_0004);
		#1 chk({31'h0, irq}, 32'h0);
		regRd(vita_pkg::OFF_STATUS, rd);
		chk(rd, 32'h0000_0009);
		regWr(8'h14, 32'hFFFF_FFFF);
		regRd(8'h14, rd);
		chk(rd, 32'h0);
		regRd(vita_pkg::OFF_MASK, rd);
		chk(rd, 32'h0000_0004);
		// Reset in mid-run
		@(posedge clock);
		reset <= 1'h1;
		repeat (2) @(posedge clock);
		reset <= 1'h0;
		chk({16'h0, realIntCode}, 32'h0080);
		regRd(vita_pkg::OFF_STATUS, rd);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
		regRd(vita_pkg::OFF_MASK, rd);
		chk(rd, 32'h0);
		tick(1);
		regRd(vita_pkg::OFF_TIMER, rd);
		chk(rd, 32'h0);
		finish_test();
	end
endmodule // vita_timer_assist_tb
